// ==== verilog/pwt_timer.sv ====
/*
 * Prescaled waveform timer: 8-bit prescaler, 8-bit timer with primary and
 * secondary reload latches, timer and waveform generation modes.
 * Assumes a single-cycle register port with read data one cycle later.
 */
`timescale 1ns/100ps
`include "pwt_map.svh"
// Function
// RL1: 8-bit down timer counts prescaler underflows; underflow raises request flag.
// RL2: 8-bit prescaler counts the selected source, possibly other timer underflow.
// RL3: Prescaler reloads its latch; timer reloads primary or secondary per mode.
// RL4: Write control bit picks latch-only or latch-and-counter writes.
// RL5: Prescaler address reads the live prescaler count.
// RL6: Primary address reads the live timer count in any phase.
// RL7: Secondary address reads an undefined value; latch is write-only.
// RL8: Mode register selects one of four operating modes; code runs the two one-shot codes as timer mode.
// RL9: Prescaler decrements; at zero next clock underflows and reloads, divide n+1.
// RL10: Timer mode decrements, underflows past zero, reloads primary, continues.
// RL11: Waveform mode alternates primary and secondary; output toggles each underflow.
// RL12: Software sets latch-only writes before waveform mode.
// RL13: Level bit four sets polarity: zero means primary high, secondary low.
// RL14: Bits zero and one extend primary and secondary intervals half a cycle; code extends only with the two divided sources.
// RL15: Waveform changes take effect at next period start, primary first.
// RL16: Secondary and extension bits apply only on a primary write, together.
// RL17: Software writes secondary and extensions first, primary last.
// RL18: Software avoids primary writes coinciding with secondary-phase underflow.
// RL19: Software uses extension only with prescaler zero and no other-timer source.
// RL20: Count stop bit halts counting in every mode.
// RL21: Extended interval ends on opposite source edge, half a cycle late.
module pwt_timer (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire pwt_pkg::pwt_bus_req_t bus_in,
   input wire logic other_uflow_in,
   output logic [7:0] rdata_out,
   output logic uflow_irq_out,
   output logic wave_out_pin_out,
   output logic wave_out_oe_out
);
   import pwt_pkg::*;

   logic [7:0] prescaler_latch_reg;
   logic [7:0] prescaler_reg;
   logic [7:0] primary_reload_reg;
   logic [7:0] secondary_reload_reg;
   logic [7:0] timer_reg;
   logic [7:0] mode_reg;
   logic [7:0] waveform_output_ctrl_reg;
   logic [7:0] source_reg;
   pwt_wave_cfg_t staged_cfg_reg;
   pwt_wave_cfg_t active_cfg_reg;
   logic [7:0] active_primary_reg;
   logic cfg_pending_reg;
   logic secondary_phase_reg;
   logic uflow_flag_reg;
   logic ext_wait_reg;
   logic wave_level_reg;
   logic shift_reg;
   logic [7:0] rdata_reg;
   logic src_tick;
   logic src_half;
   logic pre_uflow;
   logic tmr_zero_hit;
   logic tmr_uflow;
   logic ext_now;
   logic ext_ok;
   logic cnt_pulse;
   logic mid_pulse;
   logic phase_next;
   logic wr_direct;
   logic wr_pre;
   logic wr_pri;
   logic wr_sec;
   logic stopped;
   pwt_mode_t mode;

   assign mode = pwt_mode_t'(mode_reg[`PWT_MODE_MSB:`PWT_MODE_LSB]); // RL8
   assign stopped = mode_reg[`PWT_MODE_STOP_BIT];
   assign wr_direct = ~mode_reg[`PWT_MODE_WRCTL_BIT]; // RL4
   assign wr_pre = bus_in.wr && (bus_in.addr == `PWT_OFF_PRESCALER);
   assign wr_pri = bus_in.wr && (bus_in.addr == `PWT_OFF_PRIMARY);
   assign wr_sec = bus_in.wr && (bus_in.addr == `PWT_OFF_SECONDARY);

   // ----------------------------------------------------------------------
   // Count source
   // ----------------------------------------------------------------------
   pwt_count_source u_source (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .sel_in(pwt_src_t'(source_reg[`PWT_SRC_MSB:`PWT_SRC_LSB])),
      .other_uflow_in(other_uflow_in),
      .tick_out(src_tick),
      .half_out(src_half)
   );

   // ----------------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------------
   // Extension moves counting onto the other half of the source period
   assign cnt_pulse = shift_reg ? src_half : src_tick;
   assign mid_pulse = shift_reg ? src_tick : src_half;
   assign pre_uflow = cnt_pulse && !stopped && (prescaler_reg == 8'h00); // RL9

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prescaler_latch_reg <= `PWT_RST_PRESCALER;
      end else if (wr_pre) begin
         prescaler_latch_reg <= bus_in.wdata;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prescaler_reg <= `PWT_RST_PRESCALER;
      end else if (wr_pre && wr_direct) begin
         prescaler_reg <= bus_in.wdata; // RL4
      end else if (cnt_pulse && !stopped) begin // RL2 RL20
         if (prescaler_reg == 8'h00) begin
            prescaler_reg <= prescaler_latch_reg; // RL3 RL9
         end else begin
            prescaler_reg <= prescaler_reg - 8'h01; // RL9
         end
      end
   end

   // ----------------------------------------------------------------------
   // Reload latches and staged waveform settings
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         primary_reload_reg <= `PWT_RST_TIMER;
         secondary_reload_reg <= `PWT_RST_TIMER;
      end else begin
         if (wr_pri) begin
            primary_reload_reg <= bus_in.wdata;
         end
         if (wr_sec) begin
            secondary_reload_reg <= bus_in.wdata;
         end
      end
   end

   // Primary write snapshots secondary and extensions together
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         staged_cfg_reg <= '0;
         cfg_pending_reg <= 1'b0;
      end else if (wr_pri) begin
         staged_cfg_reg.secondary <= secondary_reload_reg; // RL16
         staged_cfg_reg.pext <= waveform_output_ctrl_reg[`PWT_WAVE_PEXT_BIT];
         staged_cfg_reg.sext <= waveform_output_ctrl_reg[`PWT_WAVE_SEXT_BIT];
         cfg_pending_reg <= 1'b1;
      end else if (tmr_uflow && secondary_phase_reg) begin
         cfg_pending_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Timer
   // ----------------------------------------------------------------------
   assign tmr_zero_hit = pre_uflow && (timer_reg == 8'h00); // RL1
   // Only the divided sources have a mid-cycle pulse to extend onto
   assign ext_ok = ~source_reg[`PWT_SRC_MSB];
   assign ext_now = ext_ok &&
      (secondary_phase_reg ? active_cfg_reg.sext : active_cfg_reg.pext);
   // Extended interval ends on the mid-cycle pulse after the zero hit
   assign tmr_uflow = (mode == PWT_MODE_WAVE) ?
      ((tmr_zero_hit && !ext_now) || (ext_wait_reg && mid_pulse && !stopped)) :
      tmr_zero_hit; // RL14 RL21

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_wait_reg <= 1'b0;
      end else if (mode != PWT_MODE_WAVE || !ext_ok || tmr_uflow) begin
         ext_wait_reg <= 1'b0;
      end else if (tmr_zero_hit && ext_now) begin
         ext_wait_reg <= 1'b1; // RL21
      end
   end

   // Each extended underflow flips counting to the other half period
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shift_reg <= 1'b0;
      end else if (mode != PWT_MODE_WAVE || !ext_ok) begin
         shift_reg <= 1'b0;
      end else if (ext_wait_reg && tmr_uflow) begin
         shift_reg <= ~shift_reg; // RL14 RL21
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timer_reg <= `PWT_RST_TIMER;
      end else if (wr_pri && wr_direct) begin
         timer_reg <= bus_in.wdata; // RL4
      end else if (tmr_uflow) begin
         if (mode == PWT_MODE_WAVE && !secondary_phase_reg) begin
            timer_reg <= active_cfg_reg.secondary; // RL3 RL11
         end else if (mode == PWT_MODE_WAVE && cfg_pending_reg) begin
            timer_reg <= primary_reload_reg; // RL15
         end else if (mode == PWT_MODE_WAVE) begin
            timer_reg <= active_primary_reg;
         end else begin
            timer_reg <= primary_reload_reg; // RL10
         end
      end else if (pre_uflow && !ext_wait_reg && timer_reg != 8'h00) begin
         timer_reg <= timer_reg - 8'h01; // RL1 RL10
      end
   end

   // Active settings swap in at the start of a primary interval, or at once outside waveform mode
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         active_cfg_reg <= '0;
         active_primary_reg <= `PWT_RST_TIMER;
      end else if ((tmr_uflow && secondary_phase_reg && cfg_pending_reg) ||
                   (mode != PWT_MODE_WAVE && cfg_pending_reg)) begin
         active_cfg_reg <= staged_cfg_reg; // RL15 RL16
         active_primary_reg <= primary_reload_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Waveform phase and output
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         secondary_phase_reg <= 1'b0;
      end else if (mode != PWT_MODE_WAVE) begin
         secondary_phase_reg <= 1'b0;
      end else if (tmr_uflow) begin
         secondary_phase_reg <= ~secondary_phase_reg; // RL11
      end
   end

   // Level bit applies at once; phase picks primary or secondary level
   assign phase_next = (mode == PWT_MODE_WAVE) && (secondary_phase_reg ^ tmr_uflow);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wave_level_reg <= 1'b1;
      end else begin
         wave_level_reg <= ~waveform_output_ctrl_reg[`PWT_WAVE_LEVEL_BIT] ^ phase_next; // RL11 RL13
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wave_out_pin_out <= 1'b0;
         wave_out_oe_out <= 1'b0;
      end else begin
         wave_out_pin_out <= wave_level_reg; // RL13
         wave_out_oe_out <= (mode == PWT_MODE_WAVE);
      end
   end

   // ----------------------------------------------------------------------
   // Underflow request flag
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         uflow_flag_reg <= 1'b0;
      end else if (tmr_uflow) begin
         uflow_flag_reg <= 1'b1; // RL1
      end else if (bus_in.wr && bus_in.addr == `PWT_OFF_STATUS &&
                   bus_in.wdata[`PWT_STAT_UFLOW_BIT]) begin
         uflow_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         uflow_irq_out <= 1'b0;
      end else begin
         uflow_irq_out <= uflow_flag_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_reg <= `PWT_RST_MODE;
         waveform_output_ctrl_reg <= `PWT_RST_WAVE;
         source_reg <= `PWT_RST_SOURCE;
      end else if (bus_in.wr) begin
         case (bus_in.addr)
            `PWT_OFF_MODE: mode_reg <= bus_in.wdata; // RL8 RL20
            `PWT_OFF_WAVE_CTRL: waveform_output_ctrl_reg <= bus_in.wdata;
            `PWT_OFF_SOURCE: source_reg <= bus_in.wdata; // RL2
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_reg <= 8'h00;
      end else if (bus_in.rd) begin
         case (bus_in.addr)
            `PWT_OFF_PRESCALER: rdata_reg <= prescaler_reg; // RL5
            `PWT_OFF_PRIMARY: rdata_reg <= timer_reg; // RL6
            `PWT_OFF_SECONDARY: rdata_reg <= `PWT_SECONDARY_READ; // RL7
            `PWT_OFF_MODE: rdata_reg <= mode_reg;
            `PWT_OFF_WAVE_CTRL: rdata_reg <= waveform_output_ctrl_reg;
            `PWT_OFF_SOURCE: rdata_reg <= source_reg;
            `PWT_OFF_STATUS: rdata_reg <= {6'h00, secondary_phase_reg, uflow_flag_reg};
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign rdata_out = rdata_reg;
endmodule // pwt_timer

// ==== verilog/pwt_map.svh ====
/*
 * Register offsets, field positions and reset values of the
 * prescaled waveform timer.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef PWT_MAP_SVH
`define PWT_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PWT_OFF_PRESCALER 4'h0
`define PWT_OFF_PRIMARY 4'h1
`define PWT_OFF_SECONDARY 4'h2
`define PWT_OFF_MODE 4'h3
`define PWT_OFF_WAVE_CTRL 4'h4
`define PWT_OFF_SOURCE 4'h5
`define PWT_OFF_STATUS 4'h6

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PWT_MODE_LSB 0
`define PWT_MODE_MSB 1
`define PWT_MODE_WRCTL_BIT 2
`define PWT_MODE_STOP_BIT 3
`define PWT_WAVE_PEXT_BIT 0
`define PWT_WAVE_SEXT_BIT 1
`define PWT_WAVE_LEVEL_BIT 4
`define PWT_SRC_LSB 0
`define PWT_SRC_MSB 1
`define PWT_STAT_UFLOW_BIT 0
`define PWT_STAT_PHASE_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PWT_RST_PRESCALER 8'hFF
`define PWT_RST_TIMER 8'hFF
`define PWT_RST_MODE 8'h00
`define PWT_RST_WAVE 8'h00
`define PWT_RST_SOURCE 8'h00
`define PWT_SECONDARY_READ 8'hFF

`endif

// ==== verilog/pwt_pkg.sv ====
/*
 * Types of the prescaled waveform timer.
 * Assumes pwt_map.svh is on the include path.
 */
package pwt_pkg;
`include "pwt_map.svh"

   typedef enum logic [1:0] {
      PWT_MODE_TIMER = 2'b00,
      PWT_MODE_WAVE = 2'b01,
      PWT_MODE_ONESHOT = 2'b10,
      PWT_MODE_WAIT_ONESHOT = 2'b11
   } pwt_mode_t;

   typedef enum logic [1:0] {
      PWT_SRC_DIV8 = 2'b00,
      PWT_SRC_DIV16 = 2'b01,
      PWT_SRC_SYS = 2'b10,
      PWT_SRC_OTHER_UFLOW = 2'b11
   } pwt_src_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pwt_bus_req_t;

   // Waveform settings applied together at a period start
   typedef struct packed {
      logic [7:0] secondary;
      logic pext;
      logic sext;
   } pwt_wave_cfg_t;
endpackage

// ==== verilog/pwt_count_source.sv ====
/*
 * Count source selector: makes a one-cycle count pulse from the chosen source
 * and, for the divided sources only, a half-cycle mid pulse.
 * Assumes the other timer's underflow arrives as a one-cycle pulse.
 */
`timescale 1ns/100ps
module pwt_count_source (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire pwt_pkg::pwt_src_t sel_in,
   input wire logic other_uflow_in,
   output logic tick_out,
   output logic half_out
);
   import pwt_pkg::*;

   logic [3:0] div_reg;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_reg <= 4'h0;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end

   // ----------------------------------------------------------------------
   // Count pulse and mid-cycle pulse
   // ----------------------------------------------------------------------
   always_comb begin
      case (sel_in)
         PWT_SRC_DIV8: begin
            tick_out = (div_reg[2:0] == 3'h7);
            half_out = (div_reg[2:0] == 3'h3);
         end
         PWT_SRC_DIV16: begin
            tick_out = (div_reg == 4'hF);
            half_out = (div_reg == 4'h7);
         end
         PWT_SRC_SYS: begin
            tick_out = 1'b1;
            half_out = 1'b0;
         end
         PWT_SRC_OTHER_UFLOW: begin
            tick_out = other_uflow_in;
            half_out = 1'b0;
         end
         default: begin
            tick_out = 1'b0;
            half_out = 1'b0;
         end
      endcase
   end
endmodule // pwt_count_source

// ==== tb/pwt_timer_props.sv ====
/* Port checker of the prescaled waveform timer.
   Bound to pwt_timer; sees only its ports. */
`timescale 1ns/100ps
module pwt_timer_props (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire pwt_pkg::pwt_bus_req_t bus_in,
   input wire logic other_uflow_in,
   input wire logic [7:0] rdata_out,
   input wire logic uflow_irq_out,
   input wire logic wave_out_pin_out,
   input wire logic wave_out_oe_out
);
   import pwt_pkg::*;
   logic mode_wr;
   logic stat_clr;
   assign mode_wr = bus_in.wr && (bus_in.addr == 4'h3);
   assign stat_clr = bus_in.wr && (bus_in.addr == 4'h6) && bus_in.wdata[0];
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // ---------------------------------------------
   // Mode selection steps
   // ---------------------------------------------
   sequence wave_sel;
      mode_wr && (bus_in.wdata[1:0] == 2'b01);
   endsequence
   sequence plain_sel;
      mode_wr && (bus_in.wdata[1:0] != 2'b01);
   endsequence
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   rd_idle_zero_a: assert property (!bus_in.rd |=> rdata_out == 8'h00)
      else $error("read data not zero");
   sec_read_ff_a: assert property (bus_in.rd && bus_in.addr == 4'h2 |=> rdata_out == 8'hFF)
      else $error("secondary read wrong");
   unmapped_rd_a: assert property (bus_in.rd && bus_in.addr > 4'h6 |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   wave_oe_on_a: assert property (wave_sel |-> ##[1:3] wave_out_oe_out)
      else $error("oe not raised");
   wave_oe_off_a: assert property (plain_sel |-> ##[1:3] !wave_out_oe_out)
      else $error("oe not dropped");
   oe_cause_a: assert property ($changed(wave_out_oe_out)
      |-> $past(mode_wr) || $past(mode_wr, 2) || $past(mode_wr, 3))
      else $error("oe changed without mode write");
   idle_level_a: assert property (bus_in.wr && bus_in.addr == 4'h4 && !wave_out_oe_out
      |-> ##3 wave_out_pin_out == !$past(bus_in.wdata[4], 3))
      else $error("idle level wrong");
   flag_sticky_a: assert property ($fell(uflow_irq_out)
      |-> $past(stat_clr) || $past(stat_clr, 2) || $past(stat_clr, 3))
      else $error("flag fell without clear");
endmodule // pwt_timer_props

bind pwt_timer pwt_timer_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .bus_in(bus_in), .other_uflow_in(other_uflow_in), .rdata_out(rdata_out),
   .uflow_irq_out(uflow_irq_out), .wave_out_pin_out(wave_out_pin_out),
   .wave_out_oe_out(wave_out_oe_out));

// ==== tb/pwt_wave_sink.sv ====
/* Receiver of the waveform pin: measures high and low run lengths.
   Assumes one clock shared with the timer. */
`timescale 1ns/100ps
module pwt_wave_sink (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic pin_in,
   input wire logic oe_in,
   output logic [15:0] hi_len_out,
   output logic [15:0] lo_len_out
);
   logic [15:0] run_reg;
   logic last_reg;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run_reg <= 16'h0001;
         last_reg <= 1'b0;
         hi_len_out <= 16'h0000;
         lo_len_out <= 16'h0000;
      end else if (!oe_in) begin
         run_reg <= 16'h0001;
         last_reg <= pin_in;
      end else if (pin_in != last_reg) begin
         // Close the finished level
         if (last_reg) begin
            hi_len_out <= run_reg;
         end else begin
            lo_len_out <= run_reg;
         end
         run_reg <= 16'h0001;
         last_reg <= pin_in;
      end else begin
         run_reg <= run_reg + 16'h0001;
      end
   end
endmodule // pwt_wave_sink

// ==== tb/tb_top.sv ====
/* Self-checking bench of the prescaled waveform timer.
   Assumes pwt_pkg, pwt_timer and the sink are compiled first. */
`timescale 1ns/100ps
module tb_top;
   import pwt_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   pwt_bus_req_t bus_in = '0;
   logic other_uflow_in = 1'b0;
   logic [7:0] rdata_out;
   logic uflow_irq_out;
   logic wave_out_pin_out;
   logic wave_out_oe_out;
   logic [15:0] hi_len;
   logic [15:0] lo_len;
   logic [7:0] rv;
   logic [7:0] keep;
   int err_count = 0;
   int n_checks = 0;
   int cycles = 0;
   always #2.5 clk_in = ~clk_in;
   pwt_timer dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in),
      .other_uflow_in(other_uflow_in), .rdata_out(rdata_out),
      .uflow_irq_out(uflow_irq_out), .wave_out_pin_out(wave_out_pin_out),
      .wave_out_oe_out(wave_out_oe_out));
   pwt_wave_sink sink (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(wave_out_pin_out),
      .oe_in(wave_out_oe_out), .hi_len_out(hi_len), .lo_len_out(lo_len));
   // ---------------------------------------------
   // Bus and compare helpers
   // ---------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      bus_in.addr <= a;
      bus_in.wdata <= d;
      bus_in.wr <= 1'b1;
      @(posedge clk_in);
      bus_in.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_in);
      bus_in.addr <= a;
      bus_in.rd <= 1'b1;
      @(posedge clk_in);
      bus_in.rd <= 1'b0;
      #1 rv = rdata_out;
   endtask
   // Primary write lands just after a primary interval starts
   task automatic wr_pri(input logic [7:0] d, input logic lvl);
      do @(posedge clk_in); while (wave_out_pin_out == lvl);
      do @(posedge clk_in); while (wave_out_pin_out != lvl);
      wr(4'h1, d);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk_in);
         other_uflow_in <= 1'b1;
         @(posedge clk_in);
         other_uflow_in <= 1'b0;
         repeat (3) @(posedge clk_in);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      rd(4'h3);
      chk(rv, 8'h00);
      rd(4'h2);
      chk(rv, 8'hFF);
      rd(4'hC);
      chk(rv, 8'h00);
      wr(4'h3, 8'h0A);
      rd(4'h3);
      chk(rv, 8'h0A);
      wr(4'h4, 8'h10);
      repeat (4) @(posedge clk_in);
      chk(wave_out_pin_out, 1'b0);
      chk(wave_out_oe_out, 1'b0);
      wr(4'h4, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_count();
      wr(4'h5, 8'h03);
      wr(4'h3, 8'h00);
      wr(4'h1, 8'h01);
      wr(4'h0, 8'h03);
      rd(4'h0);
      chk(rv, 8'h03);
      rd(4'h1);
      chk(rv, 8'h01);
      pulse(2);
      rd(4'h0);
      chk(rv, 8'h01);
      pulse(2);
      rd(4'h0);
      chk(rv, 8'h03);
      rd(4'h1);
      chk(rv, 8'h00);
      pulse(4);
      rd(4'h1);
      chk(rv, 8'h01);
      chk(uflow_irq_out, 1'b1);
      wr(4'h6, 8'h01);
      repeat (3) @(posedge clk_in);
      chk(uflow_irq_out, 1'b0);
      wr(4'h3, 8'h04);
      wr(4'h0, 8'h07);
      rd(4'h0);
      chk(rv, 8'h03);
      pulse(4);
      rd(4'h0);
      chk(rv, 8'h07);
      $display("test count done");
   endtask
   task automatic t_stop();
      wr(4'h3, 8'h0C);
      rd(4'h1);
      keep = rv;
      pulse(16);
      rd(4'h1);
      chk(rv, keep);
      $display("test stop done");
   endtask
   task automatic t_wave();
      wr(4'h5, 8'h02);
      wr(4'h3, 8'h08);
      wr(4'h0, 8'h00);
      wr(4'h2, 8'h02);
      wr(4'h1, 8'h04);
      wr(4'h3, 8'h05);
      repeat (40) @(posedge clk_in);
      chk(hi_len, 16'h0005);
      chk(lo_len, 16'h0003);
      chk(wave_out_oe_out, 1'b1);
      wr(4'h4, 8'h10);
      repeat (40) @(posedge clk_in);
      chk(hi_len, 16'h0003);
      chk(lo_len, 16'h0005);
      wr(4'h2, 8'h06);
      repeat (40) @(posedge clk_in);
      chk(hi_len, 16'h0003);
      wr_pri(8'h04, 1'b0);
      repeat (40) @(posedge clk_in);
      chk(hi_len, 16'h0007);
      $display("test wave done");
   endtask
   task automatic t_ext();
      wr(4'h5, 8'h00);
      wr(4'h4, 8'h01);
      wr(4'h2, 8'h01);
      wr_pri(8'h01, 1'b1);
      repeat (160) @(posedge clk_in);
      chk(hi_len, 16'h0014);
      chk(lo_len, 16'h0010);
      wr(4'h4, 8'h03);
      wr_pri(8'h01, 1'b1);
      repeat (160) @(posedge clk_in);
      chk(hi_len, 16'h0014);
      chk(lo_len, 16'h0014);
      $display("test extend done");
   endtask
   // ---------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_count();
      t_stop();
      t_wave();
      t_ext();
      print_verdict();
   end
endmodule // tb_top
